/* hdl/fvs_flow_serial_out.sv */
`timescale 1ns/1ps
module fvs_flow_serial_out
  import fvs_pkg::*;
#(
  parameter int unsigned CAL_W      = 24,
  parameter int unsigned FRAC_W     = FRAC_W_DEF,
  parameter logic [15:0] FLOW_SCALE = FLOW_SCALE_DEF,
  parameter logic [15:0] TEMP_SCALE = TEMP_SCALE_DEF
)(
  input  wire logic             CLK_I,
  input  wire logic             RESET_N_I,
  input  wire logic             LINK_CLK_I,
  input  wire logic             RUN_I,
  input  wire logic             SAMPLE_VALID_I,
  input  wire logic [CAL_W-1:0] FLOW_CAL_I,
  input  wire logic [CAL_W-1:0] TEMP_CAL_I,
  input  wire logic             OVF_FULL_I,
  input  wire logic             OVF_PEAK_I,
  input  wire logic             TEMP_SEL_I,
  input  wire logic             SPI_GET_I,
  input  wire logic             UART_RXD_I,
  input  wire logic             SPI_CS_N_I,
  output logic                  UART_TXD_O,
  output logic [7:0]            RX_DATA_O,
  output logic                  RX_VALID_O,
  output logic                  SAMPLE_DROP_O,
  output logic                  SPI_SCK_O,
  output logic                  SPI_CS_N_O,
  output logic                  SPI_CS_N_OE_O,
  output logic                  SPI_MOSI_O,
  output logic                  SPI_MOSI_OE_O
);

  localparam int PW = CAL_W + 17;

  if (CAL_W < 2 || FRAC_W >= PW) begin
    $error("fvs_flow_serial_out: CAL_W or FRAC_W out of range");
  end

  // Scaling, flooring shift and clamping to the documented range.
  function automatic logic [15:0] fmt_word(
    input logic signed [CAL_W-1:0] cal,
    input logic        [15:0]      scale
  );
    logic signed [PW-1:0] prod;
    logic signed [PW-1:0] lim;
    prod = PW'(cal) * $signed(PW'({1'b0, scale}));
    prod = prod >>> FRAC_W;
    lim  = $signed(PW'(MAX_POS));
    if (prod > lim) begin
      fmt_word = MAX_POS;
    end else if (prod < -lim) begin
      fmt_word = MAX_NEG;
    end else begin
      fmt_word = prod[15:0];
    end
  endfunction

  // ---------------- Main domain: sample, frame and transmitter.
  logic        rxd_s;
  logic [15:0] word_new;
  logic [7:0]  frame_byte;
  logic        frame_pend_q, frame_pend_d;
  logic [1:0]  frame_idx_q, frame_idx_d;
  logic [15:0] frame_word_q, frame_word_d;
  fvs_xfer_t   xfer_q, xfer_d;
  logic        xfer_tog_q, xfer_tog_d;
  logic        drop_q, drop_d;
  fvs_byte_t   echo_q, echo_d;
  fvs_tx_st_t  tx_st_q, tx_st_d;
  logic [9:0]  tx_sr_q, tx_sr_d;
  logic [3:0]  tx_bit_q, tx_bit_d;
  logic [CNT_W-1:0] tx_cnt_q, tx_cnt_d;
  logic        txd_q, txd_d;
  fvs_byte_t   rx_out_q, rx_out_d;

  fvs_sync3 #(
    .W       (1),
    .RST_VAL (1'b1)
  ) u_rxd_sync (
    .clk_i   (CLK_I),
    .rst_n_i (RESET_N_I),
    .d_i     (UART_RXD_I),
    .q_o     (rxd_s)
  );

  always_comb begin
    if (TEMP_SEL_I) begin
      word_new = fmt_word(TEMP_CAL_I, TEMP_SCALE);
    end else if (OVF_FULL_I) begin
      word_new = CODE_OVF;
    end else if (OVF_PEAK_I) begin
      word_new = CODE_PEAK;
    end else begin
      word_new = fmt_word(FLOW_CAL_I, FLOW_SCALE);
    end
    if (frame_idx_q < IDX_HI) begin
      frame_byte = SYNC_BYTE;
    end else if (frame_idx_q == IDX_HI) begin
      frame_byte = frame_word_q[15:8];
    end else begin
      frame_byte = frame_word_q[7:0];
    end
  end

  always_comb begin
    frame_pend_d = frame_pend_q;
    frame_idx_d  = frame_idx_q;
    frame_word_d = frame_word_q;
    xfer_d       = xfer_q;
    xfer_tog_d   = xfer_tog_q;
    drop_d       = 1'b0;
    echo_d       = echo_q;
    tx_st_d      = tx_st_q;
    tx_sr_d      = tx_sr_q;
    tx_bit_d     = tx_bit_q;
    tx_cnt_d     = tx_cnt_q;
    txd_d        = txd_q;
    case (tx_st_q)
      TX_IDLE: begin
        txd_d = 1'b1;
        // Echoes slot in between frames only, so a frame stays whole.
        if (echo_q.valid && frame_idx_q == IDX_FIRST) begin
          tx_sr_d      = {1'b1, echo_q.data, 1'b0};
          echo_d.valid = 1'b0;
          tx_st_d      = TX_SEND;
          txd_d        = 1'b0;
          tx_bit_d     = 4'h0;
          tx_cnt_d     = CNT_W'(BIT_CYC - 1);
        end else if (frame_pend_q) begin
          tx_sr_d     = {1'b1, frame_byte, 1'b0};
          frame_idx_d = frame_idx_q + 2'h1;
          if (frame_idx_q == IDX_LAST) begin
            frame_pend_d = 1'b0;
          end
          tx_st_d  = TX_SEND;
          txd_d    = 1'b0;
          tx_bit_d = 4'h0;
          tx_cnt_d = CNT_W'(BIT_CYC - 1);
        end
      end
      TX_SEND: begin
        if (tx_cnt_q != '0) begin
          tx_cnt_d = tx_cnt_q - CNT_W'(1);
        end else if (tx_bit_q == LAST_UBIT) begin
          tx_st_d = TX_IDLE;
          txd_d   = 1'b1;
        end else begin
          tx_cnt_d = CNT_W'(BIT_CYC - 1);
          tx_bit_d = tx_bit_q + 4'h1;
          tx_sr_d  = {1'b1, tx_sr_q[9:1]};
          txd_d    = tx_sr_q[1];
        end
      end
      default: begin
        tx_st_d = TX_IDLE;
        txd_d   = 1'b1;
      end
    endcase
    // A character that lands as the last echo leaves is kept.
    if (rx_out_q.valid) begin
      echo_d = rx_out_q;
    end
    // One frame pending; a newer sample before its last byte is loaded is dropped.
    if (SAMPLE_VALID_I && RUN_I) begin
      if (frame_pend_q) begin
        drop_d = 1'b1;
      end else begin
        frame_word_d = word_new;
        frame_pend_d = 1'b1;
        frame_idx_d  = IDX_FIRST;
        xfer_d.word  = word_new;
        xfer_d.push  = !SPI_GET_I;
        xfer_tog_d   = !xfer_tog_q;
      end
    end
  end

  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      frame_pend_q <= 1'b0;
      frame_idx_q  <= IDX_FIRST;
      frame_word_q <= '0;
      xfer_q       <= '0;
      xfer_tog_q   <= 1'b0;
      drop_q       <= 1'b0;
      echo_q       <= '0;
      tx_st_q      <= TX_IDLE;
      tx_sr_q      <= '1;
      tx_bit_q     <= 4'h0;
      tx_cnt_q     <= '0;
      txd_q        <= TXD_RST;
    end else begin
      frame_pend_q <= frame_pend_d;
      frame_idx_q  <= frame_idx_d;
      frame_word_q <= frame_word_d;
      xfer_q       <= xfer_d;
      xfer_tog_q   <= xfer_tog_d;
      drop_q       <= drop_d;
      echo_q       <= echo_d;
      tx_st_q      <= tx_st_d;
      tx_sr_q      <= tx_sr_d;
      tx_bit_q     <= tx_bit_d;
      tx_cnt_q     <= tx_cnt_d;
      txd_q        <= txd_d;
    end
  end

  // ---------------- Main domain: UART receiver.
  fvs_rx_st_t       rx_st_q, rx_st_d;
  logic [CNT_W-1:0] rx_cnt_q, rx_cnt_d;
  logic [3:0]       rx_bit_q, rx_bit_d;
  logic [7:0]       rx_sr_q, rx_sr_d;

  always_comb begin
    rx_st_d        = rx_st_q;
    rx_cnt_d       = rx_cnt_q;
    rx_bit_d       = rx_bit_q;
    rx_sr_d        = rx_sr_q;
    rx_out_d       = rx_out_q;
    rx_out_d.valid = 1'b0;
    case (rx_st_q)
      RX_IDLE: begin
        if (!rxd_s) begin
          rx_st_d  = RX_BUSY;
          rx_cnt_d = CNT_W'(HALF_CYC - 1);
          rx_bit_d = 4'h0;
        end
      end
      RX_BUSY: begin
        if (rx_cnt_q != '0) begin
          rx_cnt_d = rx_cnt_q - CNT_W'(1);
        end else begin
          rx_cnt_d = CNT_W'(BIT_CYC - 1);
          rx_bit_d = rx_bit_q + 4'h1;
          if (rx_bit_q == 4'h0 && rxd_s) begin
            rx_st_d = RX_IDLE;
          end else if (rx_bit_q != 4'h0 && rx_bit_q < LAST_UBIT) begin
            rx_sr_d = {rxd_s, rx_sr_q[7:1]};
          end else if (rx_bit_q == LAST_UBIT) begin
            rx_st_d = RX_IDLE;
            // A bad stop bit loses the character rather than echo junk.
            if (rxd_s) begin
              rx_out_d.valid = 1'b1;
              rx_out_d.data  = rx_sr_q;
            end
          end
        end
      end
      default: rx_st_d = RX_IDLE;
    endcase
  end

  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      rx_st_q  <= RX_IDLE;
      rx_cnt_q <= '0;
      rx_bit_q <= 4'h0;
      rx_sr_q  <= 8'h00;
      rx_out_q <= '0;
    end else begin
      rx_st_q  <= rx_st_d;
      rx_cnt_q <= rx_cnt_d;
      rx_bit_q <= rx_bit_d;
      rx_sr_q  <= rx_sr_d;
      rx_out_q <= rx_out_d;
    end
  end

  // ---------------- Link domain: serial peripheral master.
  logic [1:0]  lrst_q;
  logic        lrst_n;
  logic        cs_in_s, get_s, tog_s;
  logic        tog_seen_q, tog_seen_d;
  fvs_xfer_t   buf_q, buf_d;
  logic        push_pend_q, push_pend_d;
  fvs_sp_st_t  sp_st_q, sp_st_d;
  logic [15:0] sp_sr_q, sp_sr_d;
  logic [3:0]  sp_bit_q, sp_bit_d;
  logic        half_q, half_d;
  logic        sck_q, sck_d;
  logic        cs_n_q, cs_n_d;
  logic        cs_oe_q, cs_oe_d;
  logic        mosi_q, mosi_d;
  logic        mosi_oe_q, mosi_oe_d;

  always_ff @(posedge LINK_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      lrst_q <= 2'h0;
    end else begin
      lrst_q <= {lrst_q[0], 1'b1};
    end
  end
  assign lrst_n = lrst_q[1];

  fvs_sync3 #(
    .W       (3),
    .RST_VAL (LSYNC_RST)
  ) u_link_sync (
    .clk_i   (LINK_CLK_I),
    .rst_n_i (lrst_n),
    .d_i     ({SPI_CS_N_I, SPI_GET_I, xfer_tog_q}),
    .q_o     ({cs_in_s, get_s, tog_s})
  );

  always_comb begin
    tog_seen_d  = tog_seen_q;
    buf_d       = buf_q;
    push_pend_d = push_pend_q;
    sp_st_d     = sp_st_q;
    sp_sr_d     = sp_sr_q;
    sp_bit_d    = sp_bit_q;
    half_d      = half_q;
    sck_d       = sck_q;
    cs_n_d      = cs_n_q;
    mosi_d      = mosi_q;
    mosi_oe_d   = mosi_oe_q;
    cs_oe_d     = !get_s;
    case (sp_st_q)
      SP_IDLE: begin
        sck_d     = 1'b0;
        cs_n_d    = 1'b1;
        mosi_oe_d = 1'b0;
        if ((!get_s && push_pend_q) || (get_s && !cs_in_s)) begin
          cs_n_d      = get_s;
          push_pend_d = 1'b0;
          sp_sr_d     = buf_q.word;
          mosi_d      = buf_q.word[15];
          mosi_oe_d   = 1'b1;
          half_d      = 1'b1;
          sp_bit_d    = 4'h0;
          sp_st_d     = SP_SHIFT;
        end
      end
      SP_SHIFT: begin
        if (get_s && cs_in_s) begin
          sp_st_d   = SP_IDLE;
          sck_d     = 1'b0;
          mosi_oe_d = 1'b0;
        end else if (half_q) begin
          sck_d  = 1'b1;
          half_d = 1'b0;
          if (sp_bit_q == SPI_LAST) begin
            sp_st_d = SP_GAP;
          end else begin
            sp_bit_d = sp_bit_q + 4'h1;
          end
        end else begin
          sck_d   = 1'b0;
          sp_sr_d = {sp_sr_q[14:0], 1'b0};
          mosi_d  = sp_sr_q[14];
          half_d  = 1'b1;
        end
      end
      SP_GAP: begin
        sck_d = 1'b0;
        if (get_s && !cs_in_s) begin
          sp_sr_d  = buf_q.word;
          mosi_d   = buf_q.word[15];
          half_d   = 1'b1;
          sp_bit_d = 4'h0;
          sp_st_d  = SP_SHIFT;
        end else begin
          sp_st_d   = SP_IDLE;
          cs_n_d    = 1'b1;
          mosi_oe_d = 1'b0;
        end
      end
      default: sp_st_d = SP_IDLE;
    endcase
    // The word is held still in the main domain long before the
    // toggle settles here, so sampling it on the toggle is safe.
    if (tog_s != tog_seen_q) begin
      tog_seen_d  = tog_s;
      buf_d       = xfer_q;
      push_pend_d = xfer_q.push && !get_s;
    end
  end

  always_ff @(posedge LINK_CLK_I or negedge lrst_n) begin
    if (!lrst_n) begin
      tog_seen_q  <= 1'b0;
      buf_q       <= '0;
      push_pend_q <= 1'b0;
      sp_st_q     <= SP_IDLE;
      sp_sr_q     <= '0;
      sp_bit_q    <= 4'h0;
      half_q      <= 1'b0;
      sck_q       <= 1'b0;
      cs_n_q      <= CS_N_RST;
      cs_oe_q     <= 1'b0;
      mosi_q      <= 1'b0;
      mosi_oe_q   <= 1'b0;
    end else begin
      tog_seen_q  <= tog_seen_d;
      buf_q       <= buf_d;
      push_pend_q <= push_pend_d;
      sp_st_q     <= sp_st_d;
      sp_sr_q     <= sp_sr_d;
      sp_bit_q    <= sp_bit_d;
      half_q      <= half_d;
      sck_q       <= sck_d;
      cs_n_q      <= cs_n_d;
      cs_oe_q     <= cs_oe_d;
      mosi_q      <= mosi_d;
      mosi_oe_q   <= mosi_oe_d;
    end
  end

  assign UART_TXD_O    = txd_q;
  assign RX_DATA_O     = rx_out_q.data;
  assign RX_VALID_O    = rx_out_q.valid;
  assign SAMPLE_DROP_O = drop_q;
  assign SPI_SCK_O     = sck_q;
  assign SPI_CS_N_O    = cs_n_q;
  assign SPI_CS_N_OE_O = cs_oe_q;
  assign SPI_MOSI_O    = mosi_q;
  assign SPI_MOSI_OE_O = mosi_oe_q;

  // ---------------- Checks.
  logic [4:0] rise_cnt_q;
  always_ff @(posedge LINK_CLK_I or negedge lrst_n) begin
    if (!lrst_n) begin
      rise_cnt_q <= 5'h00;
    end else if (cs_n_q) begin
      rise_cnt_q <= 5'h00;
    end else if (!sck_q && sck_d) begin
      rise_cnt_q <= rise_cnt_q + 5'h01;
    end
  end

  property p_ovf_code;
    @(posedge CLK_I) disable iff (!RESET_N_I)
    SAMPLE_VALID_I && RUN_I && !frame_pend_q && !TEMP_SEL_I && OVF_FULL_I
    |=> frame_word_q == CODE_OVF;
  endproperty
  a_ovf_code: assert property (p_ovf_code) else $error("overflow code");

  property p_range;
    @(posedge CLK_I) disable iff (!RESET_N_I)
    $signed(frame_word_q) <= $signed(CODE_OVF)
    && $signed(frame_word_q) >= $signed(MAX_NEG);
  endproperty
  a_range: assert property (p_range) else $error("word out of range");

  property p_hi_not_sync;
    @(posedge CLK_I) disable iff (!RESET_N_I)
    tx_st_q == TX_IDLE && frame_pend_q && frame_idx_q == IDX_HI
    |=> tx_sr_q[8:1] != SYNC_BYTE;
  endproperty
  a_hi_not_sync: assert property (p_hi_not_sync) else $error("hi is sync");

  property p_sync_first;
    @(posedge CLK_I) disable iff (!RESET_N_I)
    $rose(frame_pend_q) && tx_st_q == TX_IDLE && !echo_q.valid
    |=> tx_sr_q[8:1] == SYNC_BYTE;
  endproperty
  a_sync_first: assert property (p_sync_first) else $error("no sync");

  property p_start_bit;
    @(posedge CLK_I) disable iff (!RESET_N_I)
    $fell(txd_q) |-> !txd_q [*8];
  endproperty
  a_start_bit: assert property (p_start_bit) else $error("short start");

  property p_echo;
    @(posedge CLK_I) disable iff (!RESET_N_I)
    rx_out_q.valid |=> echo_q.valid && echo_q.data == $past(rx_out_q.data);
  endproperty
  a_echo: assert property (p_echo) else $error("echo lost");

  property p_sixteen;
    @(posedge LINK_CLK_I) disable iff (!lrst_n)
    !get_s && $rose(cs_n_q) |-> $past(rise_cnt_q) == 5'h10;
  endproperty
  a_sixteen: assert property (p_sixteen) else $error("bit count");

  property p_release;
    @(posedge LINK_CLK_I) disable iff (!lrst_n)
    mosi_oe_q && !get_s |-> !cs_n_q;
  endproperty
  a_release: assert property (p_release) else $error("drive unselected");

  property p_idle_clk;
    @(posedge LINK_CLK_I) disable iff (!lrst_n)
    sp_st_q == SP_IDLE |-> !sck_q;
  endproperty
  a_idle_clk: assert property (p_idle_clk) else $error("clock idle");

  property p_mosi_hold;
    @(posedge LINK_CLK_I) disable iff (!lrst_n)
    sck_q |-> $stable(mosi_q);
  endproperty
  a_mosi_hold: assert property (p_mosi_hold) else $error("data moved");

  property p_get_start;
    @(posedge LINK_CLK_I) disable iff (!lrst_n)
    sp_st_q == SP_IDLE && get_s && !cs_in_s |=> sp_st_q == SP_SHIFT;
  endproperty
  a_get_start: assert property (p_get_start) else $error("get late");

  c_push: cover property (@(posedge LINK_CLK_I) disable iff (!lrst_n)
    !get_s && $rose(cs_n_q));
  c_get: cover property (@(posedge LINK_CLK_I) disable iff (!lrst_n)
    get_s && sp_st_q == SP_GAP ##1 sp_st_q == SP_SHIFT);
  c_echo: cover property (@(posedge CLK_I) disable iff (!RESET_N_I)
    rx_out_q.valid);
  c_drop: cover property (@(posedge CLK_I) disable iff (!RESET_N_I)
    drop_q);

endmodule

/* hdl/fvs_pkg.sv */
// Behaviour
// - Every sample leaves as 16-bit two's complement.
// - Scale calibrated value, then round toward minus infinity.
// - Overflow 7852, peak overflow 7851, magnitude max 7850.
// - UART at 19200 baud, 8N1, no handshake.
// - Echo every received UART character; one arriving while an echo waits replaces it.
// - Two sync bytes, then value high, low.
// - High value byte never equals sync byte.
// - UART both ways; serial link transmit only.
// - Auto-forward sends serial word with UART frame.
// - On-request sends buffered word when select falls.
// - Device always generates the serial clock.
// - MSB first, data valid after falling edge.
// - Auto-forward select low for exactly 16 bits.
// - Data output released whenever device not selected; on request, only once the synchronized select rise arrives.
package fvs_pkg;

  localparam int unsigned CLK_HZ     = 25_000_000;
  localparam int unsigned BAUD_RATE  = 19200;
  localparam int unsigned BIT_CYC    = CLK_HZ / BAUD_RATE;
  localparam int unsigned HALF_CYC   = BIT_CYC / 2;
  localparam int unsigned CNT_W      = $clog2(BIT_CYC + 1);
  localparam int unsigned DATA_BITS  = 8;
  localparam int unsigned STOP_BITS  = 1;
  localparam logic [3:0]  LAST_UBIT  = 4'(DATA_BITS + STOP_BITS);
  localparam logic [7:0]  SYNC_BYTE  = 8'h7F;
  localparam logic [1:0]  IDX_FIRST  = 2'h0;
  localparam logic [1:0]  IDX_HI     = 2'h2;
  localparam logic [1:0]  IDX_LAST   = 2'h3;
  localparam logic [15:0] CODE_OVF   = 16'h7852;
  localparam logic [15:0] CODE_PEAK  = 16'h7851;
  localparam logic [15:0] MAX_POS    = 16'h7850;
  localparam logic [15:0] MAX_NEG    = 16'h87B0;
  localparam int unsigned WORD_W     = 16;
  localparam logic [3:0]  SPI_LAST   = 4'hF;
  localparam int unsigned FRAC_W_DEF = 8;
  localparam logic [15:0] FLOW_SCALE_DEF = 16'h0080;
  localparam logic [15:0] TEMP_SCALE_DEF = 16'h0064;
  localparam logic        TXD_RST    = 1'b1;
  localparam logic        CS_N_RST   = 1'b1;
  localparam logic [2:0]  LSYNC_RST  = 3'h4;

  typedef struct packed {
    logic              push;
    logic [WORD_W-1:0] word;
  } fvs_xfer_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } fvs_byte_t;

  typedef enum logic [0:0] {TX_IDLE, TX_SEND} fvs_tx_st_t;
  typedef enum logic [0:0] {RX_IDLE, RX_BUSY} fvs_rx_st_t;
  typedef enum logic [1:0] {SP_IDLE, SP_SHIFT, SP_GAP} fvs_sp_st_t;

endpackage

/* hdl/fvs_sync3.sv */
`timescale 1ns/1ps
module fvs_sync3 #(
  parameter int unsigned    W       = 1,
  parameter logic [W-1:0]   RST_VAL = '0
)(
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);

  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  logic [W-1:0] out_q;
  logic [W-1:0] out_d;

  // A bit only moves once the second and third stage agree, which
  // also rejects a single-cycle glitch on the pin.
  always_comb begin
    out_d = out_q;
    for (int i = 0; i < W; i++) begin
      if (s2_q[i] == s3_q[i]) begin
        out_d[i] = s3_q[i];
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s1_q  <= RST_VAL;
      s2_q  <= RST_VAL;
      s3_q  <= RST_VAL;
      out_q <= RST_VAL;
    end else begin
      s1_q  <= d_i;
      s2_q  <= s1_q;
      s3_q  <= s2_q;
      out_q <= out_d;
    end
  end

  assign q_o = out_q;

endmodule

/* sim/fvs_flow_serial_out_tb.sv */
`timescale 1ns/1ps
module fvs_flow_serial_out_tb
  import fvs_pkg::*;
;
  logic        CLK_I = 1'b0;
  logic        RESET_N_I = 1'b0;
  logic        LINK_CLK_I = 1'b0;
  logic        RUN_I = 1'b1;
  logic        SAMPLE_VALID_I = 1'b0;
  logic [23:0] FLOW_CAL_I = 24'h000000;
  logic [23:0] TEMP_CAL_I = 24'h000000;
  logic        TEMP_SEL_I = 1'b0;
  logic        SPI_GET_I = 1'b0;
  logic        UART_RXD_I = 1'b1;
  logic        OVF_FULL_I = 1'b0;
  logic        OVF_PEAK_I = 1'b0;
  logic        req = 1'b0;
  logic        UART_TXD_O, RX_VALID_O, SAMPLE_DROP_O, SPI_SCK_O;
  logic        SPI_CS_N_O, SPI_CS_N_OE_O, SPI_MOSI_O, SPI_MOSI_OE_O;
  logic [7:0]  RX_DATA_O;
  logic        host_cs_n;
  logic [15:0] host_word;
  int          host_words;
  int          fail_count;
  int          cmp_count;
  int          rx_pulses = 0;
  wire         cs_w = SPI_CS_N_OE_O ? SPI_CS_N_O : host_cs_n;
  // A released data line shows the inverse of its last bit.
  wire         mosi_w = SPI_MOSI_OE_O ? SPI_MOSI_O : !SPI_MOSI_O;
  always #20 CLK_I = ~CLK_I;
  initial begin
    #7;
    forever #80 LINK_CLK_I = ~LINK_CLK_I;
  end
  always @(posedge CLK_I) begin
    if (RX_VALID_O === 1'b1) begin
      rx_pulses++;
    end
  end
  fvs_flow_serial_out u_dut (
    .CLK_I(CLK_I), .RESET_N_I(RESET_N_I), .LINK_CLK_I(LINK_CLK_I),
    .RUN_I(RUN_I), .SAMPLE_VALID_I(SAMPLE_VALID_I),
    .FLOW_CAL_I(FLOW_CAL_I), .TEMP_CAL_I(TEMP_CAL_I),
    .OVF_FULL_I(OVF_FULL_I), .OVF_PEAK_I(OVF_PEAK_I),
    .TEMP_SEL_I(TEMP_SEL_I),
    .SPI_GET_I(SPI_GET_I), .UART_RXD_I(UART_RXD_I),
    .SPI_CS_N_I(cs_w), .UART_TXD_O(UART_TXD_O), .RX_DATA_O(RX_DATA_O),
    .RX_VALID_O(RX_VALID_O), .SAMPLE_DROP_O(SAMPLE_DROP_O),
    .SPI_SCK_O(SPI_SCK_O), .SPI_CS_N_O(SPI_CS_N_O),
    .SPI_CS_N_OE_O(SPI_CS_N_OE_O), .SPI_MOSI_O(SPI_MOSI_O),
    .SPI_MOSI_OE_O(SPI_MOSI_OE_O));
  fvs_host_model u_host (
    .link_clk_i(LINK_CLK_I), .sck_i(SPI_SCK_O), .cs_n_i(cs_w),
    .mosi_i(mosi_w), .req_i(req), .cs_n_o(host_cs_n),
    .word_o(host_word), .words_o(host_words));
  task automatic conclude();
    if (fail_count == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge CLK_I);
    #1;
  endtask
  task automatic smp(input logic [23:0] f, input logic [23:0] t);
    FLOW_CAL_I = f;
    TEMP_CAL_I = t;
    SAMPLE_VALID_I = 1'b1;
    tick(1);
    SAMPLE_VALID_I = 1'b0;
  endtask
  task automatic uart_put(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      UART_RXD_I = f[i];
      tick(BIT_CYC);
    end
  endtask
  // Samples each bit at its middle; the stop bit is checked too.
  task automatic uart_get(output logic [7:0] b);
    int n;
    n = 0;
    while (UART_TXD_O !== 1'b0 && n < 20000) begin
      tick(1);
      n++;
    end
    if (n >= 20000) begin
      fail_count++;
      conclude();
    end
    tick(HALF_CYC);
    for (int i = 0; i < 8; i++) begin
      tick(BIT_CYC);
      b[i] = UART_TXD_O;
    end
    tick(BIT_CYC);
    check(16'(UART_TXD_O), 16'h0001);
  endtask
  task automatic sc_auto_flow();
    logic [7:0] b;
    logic [7:0] e [4];
    logic       seen;
    e = '{8'h7F, 8'h7F, 8'hFF, 8'h7F};
    check(16'(SPI_SCK_O), 16'h0000);
    check(16'(SPI_MOSI_OE_O), 16'h0000);
    check(16'(SPI_CS_N_O), 16'h0001);
    RUN_I = 1'b0;
    smp(24'h000300, 24'h000000);
    tick(20);
    check(16'(UART_TXD_O), 16'h0001);
    RUN_I = 1'b1;
    // Minus 257 scaled by one half must round down to minus 129.
    smp(24'hFFFEFF, 24'h000000);
    tick(5);
    smp(24'h000100, 24'h000000);
    seen = 1'b0;
    repeat (3) begin
      seen = seen | SAMPLE_DROP_O;
      tick(1);
    end
    check(16'(seen), 16'h0001);
    fork
      uart_put(8'h5A);
      for (int i = 0; i < 4; i++) begin
        uart_get(b);
        check(16'(b), 16'(e[i]));
      end
    join
    uart_get(b);
    check(16'(b), 16'h005A);
    check(16'(rx_pulses), 16'h0001);
    check(16'(RX_DATA_O), 16'h005A);
    check(host_word, 16'hFF7F);
    check(16'(host_words), 16'h0001);
  endtask
  task automatic sc_get_temp();
    logic [7:0] b;
    logic [7:0] e [3];
    int         n;
    e = '{8'h7F, 8'h7F, 8'h12};
    tick(700);
    TEMP_SEL_I = 1'b1;
    SPI_GET_I = 1'b1;
    tick(60);
    check(16'(SPI_CS_N_OE_O), 16'h0000);
    smp(24'h000000, 24'd11930);
    fork
      for (int i = 0; i < 3; i++) begin
        uart_get(b);
        check(16'(b), 16'(e[i]));
      end
      begin
        tick(60);
        req = 1'b1;
        n = 0;
        while (host_words == 1 && n < 2000) begin
          tick(1);
          n++;
        end
        req = 1'b0;
        if (n >= 2000) begin
          fail_count++;
          conclude();
        end
        check(host_word, 16'h1234);
        tick(40);
        check(16'(SPI_MOSI_OE_O), 16'h0000);
        check(16'(SPI_SCK_O), 16'h0000);
      end
    join
  endtask
  task automatic sc_ovf();
    int n;
    TEMP_SEL_I = 1'b0;
    SPI_GET_I = 1'b0;
    OVF_FULL_I = 1'b1;
    OVF_PEAK_I = 1'b1;
    // The last byte of the previous frame must be loaded first.
    tick(1400);
    smp(24'h000100, 24'h000000);
    n = 0;
    while (host_words == 2 && n < 2000) begin
      tick(1);
      n++;
    end
    if (n >= 2000) begin
      fail_count++;
      conclude();
    end
    check(host_word, CODE_OVF);
    check(16'(host_words), 16'h0003);
  endtask
  initial begin
    fail_count = 0;
    cmp_count = 0;
    // Three cycles span a link clock edge, which the link reset needs.
    tick(3);
    RESET_N_I = 1'b1;
    tick(20);
    sc_auto_flow();
    sc_get_temp();
    sc_ovf();
    conclude();
  end
endmodule

/* sim/fvs_host_model.sv */
`timescale 1ns/1ps
// Host on the serial link: it has no return data line at all.
module fvs_host_model (
  input  wire logic   link_clk_i,
  input  wire logic   sck_i,
  input  wire logic   cs_n_i,
  input  wire logic   mosi_i,
  input  wire logic   req_i,
  output logic        cs_n_o,
  output logic [15:0] word_o,
  output int          words_o
);
  logic [15:0] sh_q;
  int          bits_q;
  int          base_q;
  initial begin
    cs_n_o  = 1'b1;
    word_o  = 16'h0000;
    words_o = 0;
    bits_q  = 0;
    base_q  = 0;
  end
  // Sample on the rise, since data only moves after the fall.
  always @(posedge sck_i) begin
    if (!cs_n_i) begin
      sh_q = {sh_q[14:0], mosi_i};
      bits_q++;
      if (bits_q == 16) begin
        word_o = sh_q;
        words_o++;
        bits_q = 0;
      end
    end
  end
  always @(posedge cs_n_i) begin
    bits_q = 0;
  end
  // Select is released after one word, else it would repeat.
  always @(posedge link_clk_i) begin
    if (!cs_n_o && words_o != base_q) begin
      cs_n_o <= 1'b1;
    end else if (req_i && cs_n_o) begin
      cs_n_o <= 1'b0;
      base_q <= words_o;
    end
  end
endmodule
